// file: rtl/prom_read_control.v
// Read-side control of a configuration PROM streaming its bitstream to a loader.
// Assumes loader pins arrive asynchronously; register port is on clock_i.
//
// Operation
// - Hold output-enable/reset low after power-up until ready, about 1 ms.
// - Supply below threshold fully resets address counter and output control.
// - Chip enable high puts the device in standby regardless of output-enable/reset.
// - Chip enable deasserted holds read address at its reset value.
// - In standby data floats and cascade-enable stays high; bit 4 still follows the config pulse when pulse routing is on.
// - Terminal count is highest address; the next step wraps to zero, marks exhausted.
// - Control bits are written separately and never alter the array.
// - Control bits select read protection, parallel output, pulse routing to bit 4 (serial mode only).
// - Advance address and bit counters on each valid loader clock rising edge.
// - Output-enable/reset low with chip enable low clears the counters.
// - Serial one bit per clock by default; parallel gives one byte per clock.
// - After the last data, the next clock asserts cascade-enable and floats data; bit 4 still follows the config pulse when pulse routing is on.
//
// Implementation choices: the register offsets and strobed register access.
`include "prom_ctrl_map.vh"

module prom_read_control
#(
	parameter [19:0] READY_CYCLES = `POWERUP_CYCLES
)
(
	input  wire                   clock_i,
	input  wire                   rst_i,
	input  wire                   ce_i,
	input  wire                   loader_clock_i,
	input  wire                   chip_enable_n_i,
	input  wire                   oe_reset_in_i,
	output wire                   oe_reset_out_o,
	output reg                    oe_reset_oe_o,
	input  wire                   supply_low_i,
	input  wire                   config_pulse_n_i,
	output reg  [7:0]             data_o,
	output reg  [7:0]             data_oe_o,
	output reg                    cascade_enable_out_n_o,
	output reg                    standby_o,
	input  wire [`REG_AW-1:0]     reg_addr_i,
	input  wire [31:0]            reg_wdata_i,
	input  wire                   reg_wr_i,
	input  wire                   reg_rd_i,
	output reg  [31:0]            reg_rdata_o
);

	// Three-stage synchronisers; a change counts once stages two and three agree
	localparam [`PIN_COUNT-1:0] PIN_RST = `PIN_RESET_LEVELS;

	wire [`PIN_COUNT-1:0] pin_raw;
	wire [`PIN_COUNT-1:0] pin_s2;
	wire [`PIN_COUNT-1:0] pin_s3;
	wire [`PIN_COUNT-1:0] pin_lvl;

	assign pin_raw[`PIN_LOADER_CLOCK] = loader_clock_i;
	assign pin_raw[`PIN_CHIP_EN_N]    = chip_enable_n_i;
	assign pin_raw[`PIN_OE_RESET]     = oe_reset_in_i;
	assign pin_raw[`PIN_SUPPLY_LOW]   = supply_low_i;

	// All stages of a pin share one always block so every flop has exactly one driver
	genvar g;
	generate
		for (g = 0; g < `PIN_COUNT; g = g + 1)
		begin : sync
			reg s1_reg;
			reg s2_reg;
			reg s3_reg;
			reg lvl_reg;

			always @(posedge clock_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					s1_reg  <= PIN_RST[g];
					s2_reg  <= PIN_RST[g];
					s3_reg  <= PIN_RST[g];
					lvl_reg <= PIN_RST[g];
				end
				else if (ce_i)
				begin
					s1_reg <= pin_raw[g];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg)
						lvl_reg <= s3_reg;
				end
			end

			assign pin_s2[g]  = s2_reg;
			assign pin_s3[g]  = s3_reg;
			assign pin_lvl[g] = lvl_reg;
		end
	endgenerate

	wire ldr_agree = pin_s2[`PIN_LOADER_CLOCK] == pin_s3[`PIN_LOADER_CLOCK];
	wire ldr_rise  = ldr_agree && pin_s3[`PIN_LOADER_CLOCK]
		&& !pin_lvl[`PIN_LOADER_CLOCK];
	wire ce_n_lvl  = pin_lvl[`PIN_CHIP_EN_N];
	wire oe_lvl    = pin_lvl[`PIN_OE_RESET];
	wire brownout  = pin_lvl[`PIN_SUPPLY_LOW];

	// Power-up ready timer, restarted by a brown-out
	reg [19:0] ready_cnt_reg;
	reg        ready_reg;

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ready_cnt_reg <= 20'h00000;
			ready_reg     <= 1'b0;
		end
		else if (ce_i)
		begin
			if (brownout)
			begin
				ready_cnt_reg <= 20'h00000;
				ready_reg     <= 1'b0;
			end
			else if (!ready_reg)
			begin
				if (ready_cnt_reg >= READY_CYCLES - 20'h00001)
					ready_reg <= 1'b1;
				else
					ready_cnt_reg <= ready_cnt_reg + 20'h00001;
			end
		end
	end

	// Pin is only ever pulled low; the external pull-up releases it
	assign oe_reset_out_o = 1'b0;

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
			oe_reset_oe_o <= 1'b1;
		else if (ce_i)
			oe_reset_oe_o <= !ready_reg || brownout;
	end

	// Control bits live apart from the array
	reg [2:0] ctrl_reg;
	wire      protect_on  = ctrl_reg[`CTRL_READ_PROTECT];
	wire      parallel_on = ctrl_reg[`CTRL_PARALLEL];
	wire      cf_route_on = ctrl_reg[`CTRL_CF_ROUTE] && !parallel_on;

	// Streaming state
	reg [`ARRAY_AW-1:0] addr_reg;
	reg [2:0]           bit_reg;
	reg                 exhausted_reg;
	wire                standby   = ce_n_lvl;
	wire                streaming = ready_reg && !brownout && !standby && oe_lvl;
	wire                at_tc     = (addr_reg == {`ARRAY_AW{1'b1}})
		&& (parallel_on || bit_reg == `SERIAL_LAST_BIT);

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			addr_reg      <= {`ARRAY_AW{1'b0}};
			bit_reg       <= 3'h0;
			exhausted_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			if (!streaming)
			begin
				addr_reg      <= {`ARRAY_AW{1'b0}};
				bit_reg       <= 3'h0;
				exhausted_reg <= 1'b0;
			end
			else if (ldr_rise && !exhausted_reg)
			begin
				if (at_tc)
				begin
					addr_reg      <= {`ARRAY_AW{1'b0}};
					bit_reg       <= 3'h0;
					exhausted_reg <= 1'b1;
				end
				else if (parallel_on || bit_reg == `SERIAL_LAST_BIT)
				begin
					addr_reg <= addr_reg + {{(`ARRAY_AW-1){1'b0}}, 1'b1};
					bit_reg  <= 3'h0;
				end
				else
					bit_reg <= bit_reg + 3'h1;
			end
		end
	end

	// Array programming port
	reg  [`ARRAY_AW-1:0] ptr_reg;
	reg  [`ARRAY_AW-1:0] ptr_next;
	wire                 wr_ptr   = reg_wr_i && reg_addr_i == `REG_ARRAY_PTR;
	wire                 wr_data  = reg_wr_i && reg_addr_i == `REG_ARRAY_DATA;
	// Programming is refused while the loader is streaming
	wire                 arr_wr   = wr_data && !streaming;
	wire [`ARRAY_DW-1:0] mem_q;

	always @*
	begin
		ptr_next = ptr_reg;
		if (wr_ptr)
			ptr_next = reg_wdata_i[`ARRAY_AW-1:0];
		else if (arr_wr)
			ptr_next = ptr_reg + {{(`ARRAY_AW-1){1'b0}}, 1'b1};
	end

	// Idle read port follows the pointer so a readback is ready one cycle on
	wire [`ARRAY_AW-1:0] rd_addr = streaming ? addr_reg : ptr_next;

	prom_array array_u
	(
		.clock_i   (clock_i),
		.ce_i      (ce_i),
		.wr_en_i   (arr_wr),
		.wr_addr_i (ptr_reg),
		.wr_data_i (reg_wdata_i[`ARRAY_DW-1:0]),
		.rd_addr_i (rd_addr),
		.rd_data_o (mem_q)
	);

	// Register port
	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ctrl_reg    <= `CTRL_RESET;
			ptr_reg     <= {`ARRAY_AW{1'b0}};
			reg_rdata_o <= 32'h00000000;
		end
		else if (ce_i)
		begin
			ptr_reg <= ptr_next;
			if (reg_wr_i && reg_addr_i == `REG_CTRL)
				ctrl_reg <= reg_wdata_i[2:0];
			reg_rdata_o <= 32'h00000000;
			if (reg_rd_i)
			begin
				case (reg_addr_i)
					`REG_CTRL:
						reg_rdata_o <= {29'h0, ctrl_reg};
					`REG_STATUS:
						reg_rdata_o <= {27'h0, brownout, streaming, exhausted_reg,
							standby, ready_reg};
					`REG_POSITION:
						reg_rdata_o <= {19'h0, bit_reg, addr_reg};
					`REG_ARRAY_PTR:
						reg_rdata_o <= {22'h0, ptr_reg};
					`REG_ARRAY_DATA:
						// Protected or busy array reads back as zero
						reg_rdata_o <= (protect_on || streaming) ? 32'h00000000
							: {24'h0, mem_q};
					default:
						reg_rdata_o <= 32'h00000000;
				endcase
			end
		end
	end

	// Output pins; serial data go out most significant bit first
	wire       drive   = streaming && !exhausted_reg;
	wire [2:0] bit_sel = `SERIAL_LAST_BIT - bit_reg;
	reg  [7:0] data_next;
	reg  [7:0] oe_next;

	always @*
	begin
		data_next = 8'h00;
		oe_next   = 8'h00;
		if (drive)
		begin
			if (parallel_on)
			begin
				data_next = mem_q;
				oe_next   = 8'hff;
			end
			else
			begin
				data_next = {7'h00, mem_q[bit_sel]};
				oe_next   = 8'h01;
			end
		end
		if (cf_route_on)
		begin
			data_next[4] = 1'b0;
			oe_next[4]   = !config_pulse_n_i;
		end
	end

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			data_o                 <= 8'h00;
			data_oe_o              <= 8'h00;
			cascade_enable_out_n_o <= 1'b1;
			standby_o              <= 1'b1;
		end
		else if (ce_i)
		begin
			data_o                 <= data_next;
			data_oe_o              <= oe_next;
			cascade_enable_out_n_o <= !(streaming && exhausted_reg);
			standby_o              <= standby;
		end
	end

endmodule

// file: rtl/prom_ctrl_map.vh
// Constants for the configuration PROM read controller.
// Assumes a 250 MHz system clock and a byte-wide storage array.
`ifndef PROM_CTRL_MAP_VH
`define PROM_CTRL_MAP_VH

`define CLK_PERIOD_NS     4
`define POWERUP_TIME_US   1000
`define POWERUP_CYCLES    ((`POWERUP_TIME_US * 1000) / `CLK_PERIOD_NS)

`define ARRAY_AW          10
`define ARRAY_DEPTH       1024
`define ARRAY_DW          8

`define REG_AW            8
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_POSITION      8'h08
`define REG_ARRAY_PTR     8'h0c
`define REG_ARRAY_DATA    8'h10

`define CTRL_READ_PROTECT 0
`define CTRL_PARALLEL     1
`define CTRL_CF_ROUTE     2
`define CTRL_RESET        3'h0

`define STAT_READY        0
`define STAT_STANDBY      1
`define STAT_EXHAUSTED    2
`define STAT_STREAMING    3
`define STAT_BROWNOUT     4

// Pin order in the synchroniser vector and the level each filter starts at
`define PIN_LOADER_CLOCK  0
`define PIN_CHIP_EN_N     1
`define PIN_OE_RESET      2
`define PIN_SUPPLY_LOW    3
`define PIN_COUNT         4
`define PIN_RESET_LEVELS  4'h2

`define SERIAL_LAST_BIT   3'h7

`endif

// file: rtl/prom_array.v
// Byte-wide storage array of the configuration PROM.
// One write port and one read port; read data come out of a register.
`include "prom_ctrl_map.vh"

module prom_array
(
	input  wire                   clock_i,
	input  wire                   ce_i,
	input  wire                   wr_en_i,
	input  wire [`ARRAY_AW-1:0]   wr_addr_i,
	input  wire [`ARRAY_DW-1:0]   wr_data_i,
	input  wire [`ARRAY_AW-1:0]   rd_addr_i,
	output reg  [`ARRAY_DW-1:0]   rd_data_o
);

	reg [`ARRAY_DW-1:0] cells [0:`ARRAY_DEPTH-1];

	// Contents are nonvolatile in spirit, so no reset reaches the cells
	always @(posedge clock_i)
	begin
		if (ce_i)
		begin
			if (wr_en_i)
				cells[wr_addr_i] <= wr_data_i;
			rd_data_o <= cells[rd_addr_i];
		end
	end

endmodule

// file: verification/prom_read_control_assertions.sv
// Pin-level checks for the PROM read controller.
// Assumes one clock domain and sees only the top-level ports.
module prom_read_control_assertions
(
	input wire       clock_i,
	input wire       rst_i,
	input wire       ce_i,
	input wire       chip_enable_n_i,
	input wire       oe_reset_in_i,
	input wire       oe_reset_out_o,
	input wire       oe_reset_oe_o,
	input wire       supply_low_i,
	input wire [7:0] data_oe_o,
	input wire       cascade_enable_out_n_o,
	input wire       standby_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bit 4 may carry the pulse function, so float checks leave it out
	wire [7:0] drv;
	assign drv = data_oe_o & 8'hef;
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i || !ce_i);
	sequence s_oe_low; !oe_reset_in_i [*8]; endsequence
	sequence s_chip_off; chip_enable_n_i [*8]; endsequence
	a_standby_float: assert property (standby_o [*3] |-> drv == 8'h00 && cascade_enable_out_n_o)
		else $error("standby drives");
	a_chip_standby: assert property (s_chip_off |=> standby_o)
		else $error("no standby");
	a_oe_low_clears: assert property (s_oe_low |=> cascade_enable_out_n_o && drv == 8'h00)
		else $error("oe low kept state");
	a_brownout_pull: assert property (supply_low_i [*6] |=> oe_reset_oe_o)
		else $error("brown-out not seen");
	a_ready_float: assert property (oe_reset_oe_o [*4] |-> drv == 8'h00)
		else $error("drives before ready");
	a_oe_out_zero: assert property (oe_reset_out_o == 1'b0)
		else $error("reset pin driven high");
	a_parallel_lane: assert property (data_oe_o[7:5] != 3'h0 |-> data_oe_o == 8'hff)
		else $error("partial byte lane");
	a_cascade_float: assert property (!cascade_enable_out_n_o |-> drv == 8'h00)
		else $error("drives after last");
	// A brown-out legally ends the cascade state, so it is left out of the hold
	a_cascade_hold: assert property (!cascade_enable_out_n_o && !chip_enable_n_i && oe_reset_in_i
		&& !supply_low_i
		|=> !cascade_enable_out_n_o)
		else $error("cascade released");
endmodule
bind prom_read_control prom_read_control_assertions chk_i (.clock_i(clock_i), .rst_i(rst_i),
	.ce_i(ce_i), .chip_enable_n_i(chip_enable_n_i), .oe_reset_in_i(oe_reset_in_i),
	.oe_reset_out_o(oe_reset_out_o), .oe_reset_oe_o(oe_reset_oe_o), .supply_low_i(supply_low_i),
	.data_oe_o(data_oe_o), .cascade_enable_out_n_o(cascade_enable_out_n_o), .standby_o(standby_o));

// file: verification/prom_loader_model.sv
// Loader model: makes the loader clock and the pulled-up reset wire.
// Assumes the bench calls pulse for every clock it wants.
module prom_loader_model
(
	input  wire clock_i,
	input  wire oe_reset_oe_i,
	input  wire init_low_i,
	output reg  loader_clock_o = 1'b0,
	output wire oe_reset_wire_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pulled high unless either side pulls it low
	assign oe_reset_wire_o = !(oe_reset_oe_i || init_low_i);
	// Clock stands low between pulses; half period of 8 system cycles
	task pulse;
		repeat (8) @(posedge clock_i);
		loader_clock_o <= 1'b1;
		repeat (8) @(posedge clock_i);
		loader_clock_o <= 1'b0;
	endtask
endmodule

// file: verification/test_prom_read_control.sv
// Bench for the PROM read controller with a loader model on its pins.
// Assumes READY_CYCLES of 20 and a byte pattern loaded over the register port.
`include "prom_ctrl_map.vh"
module test_prom_read_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        chip_en_n = 1'b1;
	logic        init_low = 1'b0;
	logic        supply_low = 1'b0;
	logic        ce = 1'b1;
	logic        cfg_n = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] v;
	wire         lclk, oe_wire, oe_out, oe_oe, casc_n, stby;
	wire [7:0]   dout, doe;
	wire [31:0]  rdata;
	int          err_total = 0;
	int          compares = 0;
	always #2 clock_i = ~clock_i;
	prom_loader_model ldr (.clock_i(clock_i), .oe_reset_oe_i(oe_oe), .init_low_i(init_low),
		.loader_clock_o(lclk), .oe_reset_wire_o(oe_wire));
	prom_read_control #(.READY_CYCLES(20'd20)) uut (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
		.loader_clock_i(lclk), .chip_enable_n_i(chip_en_n), .oe_reset_in_i(oe_wire),
		.oe_reset_out_o(oe_out), .oe_reset_oe_o(oe_oe), .supply_low_i(supply_low),
		.config_pulse_n_i(cfg_n), .data_o(dout), .data_oe_o(doe), .cascade_enable_out_n_o(casc_n),
		.standby_o(stby), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata));
	function automatic logic [7:0] pat(input int k);
		pat = k[7:0] ^ {k[9:8], 6'h15};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask
	task rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task pins(input logic ce_n, input logic il);
		@(posedge clock_i);
		chip_en_n <= ce_n;
		init_low <= il;
		cyc(10);
	endtask
	task wait_ready;
		for (int i = 0; i < 100 && oe_oe !== 1'b0; i++) @(posedge clock_i);
		chk(oe_oe, 32'h0);
		if (oe_oe !== 1'b0)
			test_done();
	endtask
	task t_power_up;
		cyc(2);
		chk({stby, casc_n, oe_oe, oe_out, doe}, {3'b111, 1'b0, 8'h00});
		cyc(10);
		chk(oe_oe, 32'h1);
		wait_ready();
	endtask
	task t_load_ctrl;
		wreg(`REG_ARRAY_PTR, 32'h0);
		for (int k = 0; k < `ARRAY_DEPTH; k++) wreg(`REG_ARRAY_DATA, {24'h0, pat(k)});
		wreg(`REG_CTRL, 32'h7);
		rreg(`REG_CTRL, v);
		chk(v, 32'h7);
		rreg(8'h3c, v);
		chk(v, 32'h0);
		wreg(`REG_ARRAY_PTR, 32'h5);
		rreg(`REG_ARRAY_PTR, v);
		chk(v, 32'h5);
		rreg(`REG_ARRAY_DATA, v);
		chk(v, 32'h0);
		wreg(`REG_CTRL, 32'h0);
		rreg(`REG_ARRAY_DATA, v);
		chk(v, {24'h0, pat(5)});
	endtask
	task t_serial;
		logic [7:0] b;
		pins(1'b0, 1'b0);
		for (int k = 0; k < 12; k++)
		begin
			b = pat(k / 8);
			chk({doe, dout[0]}, {8'h01, b[7 - k % 8]});
			ldr.pulse();
		end
		wreg(`REG_CTRL, 32'h4);
		@(posedge clock_i);
		cfg_n <= 1'b0;
		cyc(3);
		chk({doe[4], dout[4]}, 32'h2);
		cfg_n <= 1'b1;
		pins(1'b1, 1'b0);
		chk({stby, casc_n, doe}, {2'b11, 8'h00});
		pins(1'b0, 1'b0);
		b = pat(0);
		chk({doe, dout[0]}, {8'h01, b[7]});
		// Array is locked while streaming; byte 5 is read back in the parallel pass
		wreg(`REG_ARRAY_DATA, 32'h0);
		rreg(`REG_ARRAY_DATA, v);
		chk(v, 32'h0);
		rreg(`REG_ARRAY_PTR, v);
		chk(v, 32'h5);
	endtask
	task t_parallel;
		wreg(`REG_CTRL, 32'h2);
		pins(1'b0, 1'b1);
		chk({casc_n, doe}, {1'b1, 8'h00});
		pins(1'b0, 1'b0);
		for (int k = 0; k < `ARRAY_DEPTH; k++)
		begin
			chk({doe, dout}, {8'hff, pat(k)});
			ldr.pulse();
		end
		chk({casc_n, doe}, {1'b0, 8'h00});
		ldr.pulse();
		rreg(`REG_POSITION, v);
		chk({casc_n, doe, v[9:0]}, 32'h0);
		pins(1'b0, 1'b1);
		chk(casc_n, 32'h1);
	endtask
	task t_brownout;
		pins(1'b0, 1'b0);
		ldr.pulse();
		// A loader edge inside a clock-enable freeze must leave no trace
		ce <= 1'b0;
		ldr.pulse();
		ce <= 1'b1;
		cyc(2);
		chk({doe, dout}, {8'hff, pat(1)});
		ldr.pulse();
		supply_low <= 1'b1;
		cyc(8);
		chk({oe_oe, casc_n, doe}, {2'b11, 8'h00});
		rreg(`REG_STATUS, v);
		chk(v[`STAT_BROWNOUT], 32'h1);
		@(posedge clock_i);
		supply_low <= 1'b0;
		wait_ready();
		cyc(10);
		chk({doe, dout}, {8'hff, pat(0)});
	endtask
	task test_done;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		cyc(8);
		rst_i <= 1'b0;
		t_power_up();
		t_load_ctrl();
		t_serial();
		t_parallel();
		t_brownout();
		test_done();
	end
	initial
	begin
		#300000;
		err_total++;
		test_done();
	end
endmodule
